// ### design/freq_sweep_burst_sequencer.sv
// Sweep sequencer: serial loader, profile registers and sweep stepping.
`timescale 1ns/100ps
module freq_sweep_burst_sequencer #(
    parameter int TIME_WIDTH = sweep_pkg::TIME_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    sweep_link_if.device link,
    input wire logic waveCycleTick,
    output logic [sweep_pkg::FREQ_W-1:0] freqWord,
    output logic waveOn,
    output logic phaseReset,
    output logic sweepRunning,
    output logic [sweep_pkg::DATA_W-1:0] ctrlWord
);
    import sweep_pkg::*;

    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [1:0] sclkHist;
    logic [1:0] trigHist;
    logic abortPrev;
    logic [WORD_W-1:0] shift_r;
    logic [3:0] bitCnt_r;
    logic wordDone_r;
    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] count_r;
    logic [FREQ_W-1:0] delta_r;
    logic [FREQ_W-1:0] start_r;
    logic [DATA_W-1:0] pendLo_r;
    logic [TIME_WIDTH-1:0] interval_r;
    logic [TIME_WIDTH-1:0] burstLen_r;
    logic ctrlWrite_r;
    sweep_state_e state_r;
    logic [DATA_W-1:0] step_r;
    logic goingUp_r;
    logic [TIME_WIDTH-1:0] timer_r;
    logic [TIME_WIDTH-1:0] burstCnt_r;
    logic sclkFall;
    logic trigRise;
    logic abortRise;
    logic incrEvent;
    logic timerTick;
    logic [WORD_W-1:0] word;
    logic [ADDR_W-1:0] wordAddr;
    logic [DATA_W-1:0] wordData;

    // Every pin passes two flops before any logic reads it.
    // Reset values match each pin's idle level except serial data (reset high, host idles low), so trigger and abort show no false rise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 5'h07;
            sync2 <= 5'h07;
        end else if (clkEn) begin
            sync1 <= {link.abortReq, link.trigger, link.serialDataIn,
                      link.frameSelectN, link.sclk};
            sync2 <= sync1;
        end
    end

    // Edge history taken from the second stage only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkHist <= 2'h3;
            trigHist <= 2'h0;
            abortPrev <= 1'b0;
        end else if (clkEn) begin
            sclkHist <= {sclkHist[0], sync2[0]};
            trigHist <= {trigHist[0], sync2[3]};
            abortPrev <= sync2[4];
        end
    end

    // The clock idles high, as the reset history assumes; only a real high-to-low step counts.
    assign sclkFall = sclkHist[1] & ~sclkHist[0];
    assign trigRise = ~trigHist[1] & trigHist[0];
    assign abortRise = ~abortPrev & sync2[4];
    assign word = {shift_r[WORD_W-2:0], sync2[2]};
    assign wordAddr = word[WORD_W-1 -: ADDR_W];
    assign wordData = word[DATA_W-1:0];

    // Shift register; frame select high drops any partial word.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= '0;
            bitCnt_r <= '0;
            wordDone_r <= 1'b0;
        end else if (clkEn) begin
            wordDone_r <= 1'b0;
            if (sync2[1]) begin
                bitCnt_r <= '0;
            end else if (sclkFall) begin
                shift_r <= word;
                bitCnt_r <= bitCnt_r + 4'h1;
                wordDone_r <= (bitCnt_r == BIT_LAST[3:0]);
            end
        end
    end

    // Register decode; paired mode holds the low half until the high half arrives.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
            count_r <= '0;
            delta_r <= '0;
            start_r <= '0;
            pendLo_r <= '0;
            interval_r <= '0;
            burstLen_r <= '0;
            ctrlWrite_r <= 1'b0;
        end else if (clkEn) begin
            ctrlWrite_r <= 1'b0;
            if (wordDone_r) begin
                if (shift_r[WORD_W-1 -: 2] == ADR2_INTERVAL) begin
                    interval_r <= shift_r[TIME_WIDTH-1:0];
                end else if (shift_r[WORD_W-1 -: 2] == ADR2_BURST) begin
                    burstLen_r <= shift_r[TIME_WIDTH-1:0];
                end else begin
                    case (shift_r[WORD_W-1 -: ADDR_W])
                        ADR_CTRL: begin
                            ctrl_r <= shift_r[DATA_W-1:0];
                            ctrlWrite_r <= 1'b1;
                        end
                        ADR_COUNT: count_r <= shift_r[DATA_W-1:0];
                        ADR_DELTA_LO: begin
                            pendLo_r <= shift_r[DATA_W-1:0];
                            if (!ctrl_r[CB_PAIRED]) begin
                                delta_r[DATA_W-1:0] <= shift_r[DATA_W-1:0];
                            end
                        end
                        ADR_DELTA_HI: begin
                            delta_r[FREQ_W-1:DATA_W] <= shift_r[DATA_W-1:0];
                            if (ctrl_r[CB_PAIRED]) begin
                                delta_r[DATA_W-1:0] <= pendLo_r;
                            end
                        end
                        ADR_START_LO: begin
                            pendLo_r <= shift_r[DATA_W-1:0];
                            if (!ctrl_r[CB_PAIRED]) begin
                                start_r[DATA_W-1:0] <= shift_r[DATA_W-1:0];
                            end
                        end
                        ADR_START_HI: begin
                            start_r[FREQ_W-1:DATA_W] <= shift_r[DATA_W-1:0];
                            if (ctrl_r[CB_PAIRED]) begin
                                start_r[DATA_W-1:0] <= pendLo_r;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // Interval base is either clock cycles or output waveform cycles.
    assign timerTick = ctrl_r[CB_BY_CYCLES] ? waveCycleTick : 1'b1;
    // Step source: internal interval timer or the trigger pin.
    assign incrEvent = (state_r == SW_RUN) &&
        (ctrl_r[CB_EXT_INCR] ? trigRise
                             : (timerTick && timer_r + 1'b1 >= interval_r));

    // Sweep state, step counter and frequency word.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= SW_IDLE;
            step_r <= '0;
            goingUp_r <= 1'b1;
            freqWord <= '0;
            timer_r <= '0;
        end else if (clkEn) begin
            if (ctrlWrite_r || abortRise) begin
                state_r <= SW_IDLE;
                timer_r <= '0;
            end else begin
                case (state_r)
                    SW_IDLE: begin
                        if (trigRise) begin
                            state_r <= SW_RUN;
                            freqWord <= start_r;
                            step_r <= '0;
                            goingUp_r <= 1'b1;
                            timer_r <= '0;
                        end
                    end
                    SW_RUN: begin
                        if (incrEvent) begin
                            timer_r <= '0;
                        end else if (timerTick) begin
                            timer_r <= timer_r + 1'b1;
                        end
                        if (incrEvent && count_r != '0) begin
                            if (goingUp_r && step_r == count_r) begin
                                if (ctrl_r[CB_TRIANGLE]) begin
                                    goingUp_r <= 1'b0;
                                    step_r <= step_r - 1'b1;
                                    freqWord <= freqWord - delta_r;
                                end else begin
                                    step_r <= '0;
                                    freqWord <= start_r;
                                end
                            end else if (!goingUp_r && step_r == '0) begin
                                goingUp_r <= 1'b1;
                                step_r <= step_r + 1'b1;
                                freqWord <= freqWord + delta_r;
                            end else if (goingUp_r) begin
                                step_r <= step_r + 1'b1;
                                freqWord <= freqWord + delta_r;
                            end else begin
                                step_r <= step_r - 1'b1;
                                freqWord <= freqWord - delta_r;
                            end
                        end
                    end
                    default: state_r <= SW_IDLE;
                endcase
            end
        end
    end

    // Output gating. Continuous mode resets phase only outside a sweep, so steps are seamless.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waveOn <= 1'b0;
            phaseReset <= 1'b0;
            burstCnt_r <= '0;
        end else if (clkEn) begin
            phaseReset <= 1'b0;
            if (ctrlWrite_r || abortRise || state_r != SW_RUN) begin
                waveOn <= 1'b0;
                burstCnt_r <= '0;
                phaseReset <= 1'b1;
            end else if (ctrl_r[CB_PIN_BURST]) begin
                waveOn <= sync2[3];
            end else if (!ctrl_r[CB_OUT_MODE]) begin
                waveOn <= 1'b1;
            end else if (incrEvent) begin
                burstCnt_r <= '0;
                waveOn <= 1'b0;
                phaseReset <= 1'b1;
            end else begin
                waveOn <= burstCnt_r < burstLen_r;
                if (burstCnt_r < burstLen_r) begin
                    burstCnt_r <= burstCnt_r + 1'b1;
                end
            end
        end
    end

    // Status copies, registered so every output leaves a flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sweepRunning <= 1'b0;
            ctrlWord <= CTRL_RESET;
        end else if (clkEn) begin
            sweepRunning <= (state_r == SW_RUN);
            ctrlWord <= ctrl_r;
        end
    end
endmodule

// ### design/sweep_pkg.sv
// Shared constants for the sweep sequencer and its serial host.
package sweep_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 12;
    localparam int FREQ_W = 24;
    localparam int TIME_W = 14;
    localparam logic [4:0] BIT_LAST = 5'hF;
    // Serial word address codes in the top nibble; interval and burst use the top two bits only.
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_COUNT = 4'h1;
    localparam logic [3:0] ADR_DELTA_LO = 4'h2;
    localparam logic [3:0] ADR_DELTA_HI = 4'h3;
    localparam logic [3:0] ADR_START_LO = 4'hC;
    localparam logic [3:0] ADR_START_HI = 4'hD;
    localparam logic [1:0] ADR2_INTERVAL = 2'h1;
    localparam logic [1:0] ADR2_BURST = 2'h2;
    // Control word bit positions.
    localparam int CB_PAIRED = 11;
    localparam int CB_OUT_MODE = 7;
    localparam int CB_TRIANGLE = 6;
    localparam int CB_EXT_INCR = 5;
    localparam int CB_BY_CYCLES = 4;
    localparam int CB_PIN_BURST = 3;
    localparam logic [DATA_W-1:0] CTRL_RESET = 12'h000;
    // Host command port offsets.
    localparam logic [1:0] HOST_DATA = 2'h0;
    localparam logic [1:0] HOST_STATUS = 2'h1;
    localparam logic [1:0] HOST_PINS = 2'h2;
    localparam int HALF_PERIOD = 16;
    typedef enum logic [0:0] {SW_IDLE = 1'b0, SW_RUN = 1'b1} sweep_state_e;
    typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_SHIFT = 2'b01, HS_TAIL = 2'b10} host_state_e;
endpackage

// ### design/sweep_link_if.sv
// Pins between the serial host and the sweep sequencer.
`timescale 1ns/100ps
interface sweep_link_if;
    logic sclk;
    logic frameSelectN;
    logic serialDataIn;
    logic trigger;
    logic abortReq;
    modport host (output sclk, output frameSelectN, output serialDataIn,
                  output trigger, output abortReq);
    modport device (input sclk, input frameSelectN, input serialDataIn,
                    input trigger, input abortReq);
endinterface

// ### design/sweep_serial_host.sv
// Host end: command registers and a divided serial clock writer.
`timescale 1ns/100ps
module sweep_serial_host #(
    parameter int HALF = sweep_pkg::HALF_PERIOD
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [1:0] addr,
    input wire logic [sweep_pkg::WORD_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [sweep_pkg::WORD_W-1:0] rdData,
    sweep_link_if.host link
);
    import sweep_pkg::*;

    host_state_e state_r;
    logic [WORD_W-1:0] word_r;
    logic [4:0] edges_r;
    logic [$clog2(HALF+1)-1:0] div_r;
    logic halfDone;

    assign halfDone = (div_r == '0);

    // Serial writer: data changes while the clock is high, device samples on the fall.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= HS_IDLE;
            word_r <= '0;
            edges_r <= '0;
            div_r <= '0;
            link.sclk <= 1'b1;
            link.frameSelectN <= 1'b1;
            link.serialDataIn <= 1'b0;
        end else if (clkEn) begin
            div_r <= halfDone ? ($bits(div_r))'(HALF - 1) : div_r - 1'b1;
            case (state_r)
                HS_IDLE: begin
                    if (wrStrobe && addr == HOST_DATA) begin
                        state_r <= HS_SHIFT;
                        link.frameSelectN <= 1'b0;
                        link.serialDataIn <= wrData[WORD_W-1];
                        word_r <= {wrData[WORD_W-2:0], 1'b0};
                        edges_r <= '0;
                        div_r <= ($bits(div_r))'(HALF - 1);
                    end
                end
                HS_SHIFT: begin
                    if (halfDone) begin
                        link.sclk <= ~link.sclk;
                        if (!link.sclk) begin
                            link.serialDataIn <= word_r[WORD_W-1];
                            word_r <= {word_r[WORD_W-2:0], 1'b0};
                        end else if (edges_r == 5'(BIT_LAST)) begin
                            state_r <= HS_TAIL;
                        end else begin
                            edges_r <= edges_r + 5'h1;
                        end
                    end
                end
                HS_TAIL: begin
                    if (halfDone && !link.sclk) begin
                        link.sclk <= 1'b1;
                    end else if (halfDone) begin
                        link.frameSelectN <= 1'b1;
                        state_r <= HS_IDLE;
                    end
                end
                default: state_r <= HS_IDLE;
            endcase
        end
    end

    // Trigger and abort levels come straight from software.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.trigger <= 1'b0;
            link.abortReq <= 1'b0;
        end else if (clkEn && wrStrobe && addr == HOST_PINS) begin
            link.trigger <= wrData[0];
            link.abortReq <= wrData[1];
        end
    end

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else if (clkEn) begin
            rdData <= '0;
            if (rdStrobe) begin
                case (addr)
                    HOST_STATUS: rdData <= {15'h0000, state_r != HS_IDLE};
                    HOST_PINS: rdData <= {14'h0000, link.abortReq, link.trigger};
                    default: rdData <= '0;
                endcase
            end
        end
    end
endmodule

// ### testbench/sweep_link_properties.sv
// Concurrent checks of the serial link and the sequencer outputs.
`timescale 1ns/100ps
module sweep_link_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic frameSelectN,
    input wire logic serialDataIn,
    input wire logic trigger,
    input wire logic abortReq,
    input wire logic [sweep_pkg::FREQ_W-1:0] freqWord,
    input wire logic waveOn,
    input wire logic phaseReset,
    input wire logic sweepRunning
);
    import sweep_pkg::*;
    logic [4:0] fallCnt_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Counts serial clock falls inside a frame, so a short frame shows up at its close.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallCnt_r <= 5'h00;
        end else if (frameSelectN) begin
            fallCnt_r <= 5'h00;
        end else if ($fell(sclk)) begin
            fallCnt_r <= fallCnt_r + 5'h01;
        end
    end
    frame_count_a: assert property ($rose(frameSelectN) |-> fallCnt_r == 5'h10)
        else $error("frame closed after a partial word");
    frame_close_a: assert property ($fell(sclk) && fallCnt_r == 5'h0F |->
        (!frameSelectN)[*4] ##[1:8] $rose(frameSelectN))
        else $error("frame not closed after the last fall");
    idle_clock_a: assert property (frameSelectN |-> sclk)
        else $error("serial clock low outside a frame");
    half_period_a: assert property ($changed(sclk) |=> $stable(sclk)[*3])
        else $error("serial clock phase too short");
    data_edge_a: assert property (!frameSelectN && !$past(frameSelectN) &&
        $changed(serialDataIn) |-> $rose(sclk))
        else $error("serial data moved away from a rising clock");
    abort_stop_a: assert property ($rose(abortReq) |->
        ##[1:6] (!sweepRunning && !waveOn))
        else $error("abort did not stop the sweep");
    trigger_start_a: assert property ($rose(trigger) && !sweepRunning && !abortReq |->
        ##[1:6] sweepRunning)
        else $error("trigger did not start the sweep");
    idle_midscale_a: assert property (waveOn |-> sweepRunning || $past(sweepRunning))
        else $error("waveform out while idle");
    burst_phase_a: assert property ($rose(phaseReset) && sweepRunning |-> !waveOn)
        else $error("step began away from midscale");
    // Main scenarios that the bench is expected to reach.
    cover property ($rose(frameSelectN));
    cover property ($rose(sweepRunning));
    cover property ($rose(phaseReset) && sweepRunning);
endmodule

// ### testbench/freq_sweep_burst_sequencer_tb_top.sv
// Bench for the sweep sequencer loaded through its serial host.
`timescale 1ns/100ps
module freq_sweep_burst_sequencer_tb_top;
    import sweep_pkg::*;
    localparam logic [FREQ_W-1:0] START = 24'h000100;
    localparam logic [FREQ_W-1:0] STEP = 24'h000010;
    logic clk;
    logic rst_n;
    logic [1:0] addr;
    logic [WORD_W-1:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [WORD_W-1:0] rdData;
    logic tick;
    logic tickEn;
    logic [1:0] tickCnt;
    logic [WORD_W-1:0] wireWord;
    logic [FREQ_W-1:0] freqWord;
    logic waveOn;
    logic phaseReset;
    logic sweepRunning;
    logic [DATA_W-1:0] ctrlWord;
    int bad_count;
    int total_checks;
    sweep_link_if i_sweep_link_if();
    sweep_serial_host #(.HALF(4)) i_sweep_serial_host (.clk(clk), .rst_n(rst_n),
        .clkEn(1'b1), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .link(i_sweep_link_if.host));
    freq_sweep_burst_sequencer i_freq_sweep_burst_sequencer (.clk(clk), .rst_n(rst_n),
        .clkEn(1'b1), .link(i_sweep_link_if.device), .waveCycleTick(tick),
        .freqWord(freqWord), .waveOn(waveOn), .phaseReset(phaseReset),
        .sweepRunning(sweepRunning), .ctrlWord(ctrlWord));
    sweep_link_properties i_sweep_link_properties (.clk(clk), .rst_n(rst_n),
        .sclk(i_sweep_link_if.sclk), .frameSelectN(i_sweep_link_if.frameSelectN),
        .serialDataIn(i_sweep_link_if.serialDataIn), .trigger(i_sweep_link_if.trigger),
        .abortReq(i_sweep_link_if.abortReq), .freqWord(freqWord), .waveOn(waveOn),
        .phaseReset(phaseReset), .sweepRunning(sweepRunning));
    // Free running clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Waveform cycle ticks every fourth clock, so cycle counting is slower than clock counting.
    always @(posedge clk) begin
        tickCnt <= tickCnt + 2'h1;
        tick <= tickEn && (tickCnt == 2'h3);
    end
    // Rebuilds each word from the wire at the falling serial clock, where data is settled.
    always @(negedge i_sweep_link_if.sclk) begin
        if (!i_sweep_link_if.frameSelectN) begin
            wireWord <= {wireWord[WORD_W-2:0], i_sweep_link_if.serialDataIn};
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("%0d checks made, %0d wrong", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [WORD_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rd(input logic [1:0] a, output logic [WORD_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 d = rdData;
    endtask
    // Sends one word, polls busy with a bound and compares what crossed the wire.
    task automatic send(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] s;
        wr(HOST_DATA, w);
        for (int i = 0; i < 400; i++) begin
            rd(HOST_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        if (s[0] !== 1'b0) begin
            bad_count++;
            print_verdict();
        end
        check(wireWord, w);
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Trigger and abort levels; the wait covers the host write and input sync.
    task automatic pins(input logic t, input logic a);
        wr(HOST_PINS, {14'h0000, a, t});
        repeat (8) @(posedge clk);
        #1;
    endtask
    // Waits for the next frequency change and returns the cycles it took.
    task automatic step(input logic [FREQ_W-1:0] exp, output int n);
        logic [FREQ_W-1:0] old;
        old = freqWord;
        n = 0;
        while (freqWord === old && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 2000) begin
            bad_count++;
            print_verdict();
        end
        check(freqWord, exp);
    endtask
    // Control write first, since it stops any sweep, then the profile and a trigger.
    task automatic setup(input logic [DATA_W-1:0] c, input logic [13:0] burst);
        send({ADR_CTRL, c});
        check(sweepRunning, 1'b0);
        check(waveOn, 1'b0);
        check(ctrlWord, c);
        send({ADR_COUNT, 12'h002});
        send({ADR_DELTA_LO, STEP[11:0]});
        send({ADR_DELTA_HI, STEP[23:12]});
        send({ADR_START_LO, START[11:0]});
        send({ADR_START_HI, START[23:12]});
        send({ADR2_INTERVAL, 14'h000A});
        send({ADR2_BURST, burst});
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        check(sweepRunning, 1'b1);
        check(freqWord, START);
    endtask
    task automatic t_saw();
        int n;
        int sum;
        setup(12'h000, 14'h0003);
        check(waveOn, 1'b1);
        check(phaseReset, 1'b0);
        // The first step only ends the interval that began at the trigger, so it is not timed.
        step(START + STEP, n);
        step(START + 2 * STEP, n);
        check(n, 10);
        sum = n;
        step(START, n);
        sum += n;
        step(START + STEP, n);
        check(sum + n, 30);
        $display("saw sweep test done");
    endtask
    task automatic t_tri();
        int n;
        setup(12'h001 << CB_TRIANGLE, 14'h0003);
        step(START + STEP, n);
        step(START + 2 * STEP, n);
        step(START + STEP, n);
        check(n, 10);
        step(START, n);
        step(START + STEP, n);
        $display("triangle sweep test done");
    endtask
    task automatic t_ext();
        int n;
        setup((12'h001 << CB_EXT_INCR) | (12'h001 << CB_PIN_BURST) | (12'h001 << CB_PAIRED),
            14'h0003);
        check(waveOn, 1'b1);
        repeat (60) @(posedge clk);
        check(freqWord, START);
        pins(1'b0, 1'b0);
        check(waveOn, 1'b0);
        pins(1'b1, 1'b0);
        check(freqWord, START + STEP);
        $display("external step test done");
    endtask
    task automatic t_cycles();
        int n;
        tickEn <= 1'b1;
        setup(12'h001 << CB_BY_CYCLES, 14'h0003);
        // Ten ticks at one tick per four clocks make a full interval of forty clocks.
        step(START + STEP, n);
        step(START + 2 * STEP, n);
        check(n, 40);
        tickEn <= 1'b0;
        repeat (100) @(posedge clk);
        check(freqWord, START + 2 * STEP);
        $display("cycle interval test done");
    endtask
    task automatic t_burst();
        int n;
        int high;
        setup(12'h001 << CB_OUT_MODE, 14'h0003);
        check(ctrlWord[CB_OUT_MODE], 1'b1);
        step(START + STEP, n);
        check(phaseReset, 1'b1);
        high = 0;
        repeat (9) begin
            @(posedge clk);
            #1 high += (waveOn === 1'b1);
        end
        check(high, 3);
        pins(1'b1, 1'b1);
        check(sweepRunning, 1'b0);
        check(waveOn, 1'b0);
        pins(1'b0, 1'b0);
        $display("burst and abort test done");
    endtask
    // Reset, idle wire levels and an unmapped read, then each scenario in turn.
    initial begin
        logic [WORD_W-1:0] v;
        rst_n = 1'b0;
        addr = 2'h0;
        wrData = 16'h0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        tickEn = 1'b0;
        tickCnt = 2'h0;
        tick = 1'b0;
        bad_count = 0;
        total_checks = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(ctrlWord, CTRL_RESET);
        check(sweepRunning, 1'b0);
        check(i_sweep_link_if.frameSelectN, 1'b1);
        check(i_sweep_link_if.sclk, 1'b1);
        rd(2'h3, v);
        check(v, 16'h0000);
        repeat (4) @(posedge clk);
        #1 check(sweepRunning, 1'b0);
        $display("reset test done");
        t_saw();
        t_tri();
        t_ext();
        t_cycles();
        t_burst();
        print_verdict();
    end
endmodule
